// file: core/analog_output_channel_control.sv
// Purpose: one analog current output channel: ramp, scale, clamp and fault behaviour
// Assumes: bus value and fault inputs synchronous to clock
// Notes: gain of the scaling is recomputed by a serial divider after scaling writes
//
// What this block does
// RULE1 - in normal state output below the configured lower limit is raised to it, default zero
// RULE2 - in normal state output above the configured upper limit is cut to it, default 22
// RULE3 - flag error unless low signal is strictly below high signal
// RULE4 - fault mode selects hold last value or user substitute, default substitute
// RULE5 - in user fault mode drive the configured substitute value, default zero
// RULE6 - keep fault output for duration seconds, then switch to final value
// RULE7 - zero duration keeps the fault output forever; zero is default
// RULE8 - flag error when fault duration exceeds 7200 seconds
// RULE9 - after duration expires drive the configured final value, default zero
// RULE10 - ramping off, the default, passes each bus value straight through
// RULE11 - ramping on limits output change to the configured rate, default 1
// RULE12 - HART switch off blocks all HART attempts; default on
// RULE13 - low signal current maps to lower scale, high signal to upper scale
// RULE14 - fault enters fault handling, restarts timer, clearing fault resumes normal
`timescale 1ns/1ps
`default_nettype none
module analog_output_channel_control
    import ao_channel_pkg::*;
#(
    parameter int CyclesPerMs = CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // cyclic bus value and faults
    input wire logic [31:0] busValue,
    input wire logic busValid,
    input wire logic chanFault,
    input wire logic commFault,
    // hart gating
    input wire logic hartReq,
    output logic hartStart,
    // channel outputs
    output logic [31:0] aoOut,
    output logic faultActive,
    output var cfg_err_t cfgError
);
    cfg_t cfg_r;
    fault_state_t state_r;
    cfg_err_t cfgError_r;
    logic [31:0] regRdata_r;
    logic [31:0] target_r;
    logic [31:0] rampPos_r;
    logic [31:0] scaled_r;
    logic [31:0] aoOut_r;
    logic [31:0] holdVal_r;
    logic hartStart_r;
    logic [31:0] preCnt_r;
    logic msTick;
    logic [9:0] msCnt_r;
    logic [15:0] secCnt_r;
    logic faultNow;
    logic scaleWrite;
    logic divPending_r;
    logic divBusy_r;
    logic [5:0] divCnt_r;
    logic [48:0] divNum_r;
    logic [32:0] divDen_r;
    logic [33:0] divRem_r;
    logic divNeg_r;
    logic signed [49:0] gain_r;
    logic gainValid_r;
    assign faultNow = chanFault | commFault;
    assign scaleWrite = regWrite && (regAddr == OFS_LOW_SIGNAL || regAddr == OFS_HIGH_SIGNAL ||
                        regAddr == OFS_LOWER_SCALE || regAddr == OFS_UPPER_SCALE);
    function automatic logic [32:0] absDiff(input logic [31:0] a, input logic [31:0] b);
        logic signed [32:0] d;
        d = $signed({a[31], a}) - $signed({b[31], b});
        absDiff = d[32] ? 33'(-d) : 33'(d);
    endfunction : absDiff
    function automatic logic sgnDiff(input logic [31:0] a, input logic [31:0] b);
        sgnDiff = $signed(a) < $signed(b);
    endfunction : sgnDiff
    // register writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= '{RST_FAULT_USER, RST_RAMP_ON, RST_HART_ON, RST_LOWER_LIMIT,
                       RST_UPPER_LIMIT, RST_SUBST_VALUE, RST_DURATION, RST_FINAL_VALUE,
                       RST_RATE, RST_LOW_SIGNAL, RST_HIGH_SIGNAL, RST_LOWER_SCALE,
                       RST_UPPER_SCALE};
        end else if (regWrite) begin
            case (regAddr)
                OFS_CTRL: begin
                    cfg_r.faultUser <= regWdata[CTRL_USER_BIT];
                    cfg_r.rampOn <= regWdata[CTRL_RAMP_BIT];
                    cfg_r.hartOn <= regWdata[CTRL_HART_BIT];
                end
                OFS_LOWER_LIMIT: cfg_r.lowerLimit <= regWdata;
                OFS_UPPER_LIMIT: cfg_r.upperLimit <= regWdata;
                OFS_SUBST_VALUE: cfg_r.substValue <= regWdata;
                OFS_DURATION: cfg_r.duration <= regWdata[15:0];
                OFS_FINAL_VALUE: cfg_r.finalValue <= regWdata;
                OFS_RATE: cfg_r.rate <= (regWdata < RATE_MIN) ? RATE_MIN : regWdata;
                OFS_LOW_SIGNAL: cfg_r.lowSignal <= regWdata;
                OFS_HIGH_SIGNAL: cfg_r.highSignal <= regWdata;
                OFS_LOWER_SCALE: cfg_r.lowerScale <= regWdata;
                OFS_UPPER_SCALE: cfg_r.upperScale <= regWdata;
                default: ;
            endcase
        end
    end
    // register reads, data one cycle later
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdata_r <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                OFS_CTRL: regRdata_r <= {29'h0, cfg_r.hartOn, cfg_r.rampOn,
                                         cfg_r.faultUser};
                OFS_LOWER_LIMIT: regRdata_r <= cfg_r.lowerLimit;
                OFS_UPPER_LIMIT: regRdata_r <= cfg_r.upperLimit;
                OFS_SUBST_VALUE: regRdata_r <= cfg_r.substValue;
                OFS_DURATION: regRdata_r <= {16'h0000, cfg_r.duration};
                OFS_FINAL_VALUE: regRdata_r <= cfg_r.finalValue;
                OFS_RATE: regRdata_r <= cfg_r.rate;
                OFS_LOW_SIGNAL: regRdata_r <= cfg_r.lowSignal;
                OFS_HIGH_SIGNAL: regRdata_r <= cfg_r.highSignal;
                OFS_LOWER_SCALE: regRdata_r <= cfg_r.lowerScale;
                OFS_UPPER_SCALE: regRdata_r <= cfg_r.upperScale;
                OFS_STATUS: regRdata_r <= {26'h0, gainValid_r, cfgError_r,
                                           state_r, faultActive};
                OFS_OUTPUT: regRdata_r <= aoOut_r;
                default: regRdata_r <= 32'h0000_0000;
            endcase
        end else begin
            regRdata_r <= 32'h0000_0000;
        end
    end
    // parameter validation
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfgError_r <= '0;
        end else begin
            // RULE3 range order check
            cfgError_r.rangeOrder <= !($signed(cfg_r.lowSignal) < $signed(cfg_r.highSignal));
            // RULE8 duration limit check
            cfgError_r.durationLong <= cfg_r.duration > DURATION_MAX_S;
        end
    end
    // millisecond tick timebase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            preCnt_r <= 32'h0000_0000;
        end else if (preCnt_r == 32'(CyclesPerMs - 1)) begin
            preCnt_r <= 32'h0000_0000;
        end else begin
            preCnt_r <= preCnt_r + 32'h0000_0001;
        end
    end
    assign msTick = (preCnt_r == 32'(CyclesPerMs - 1));
    // target latch and ramp
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            target_r <= RST_LOWER_SCALE;
            rampPos_r <= RST_LOWER_SCALE;
        end else begin
            if (busValid) begin
                target_r <= busValue;
            end
            if (!cfg_r.rampOn) begin
                // RULE10 direct output
                rampPos_r <= target_r;
            end else if (msTick) begin
                // RULE11 rate limited step
                if (absDiff(target_r, rampPos_r) <= {1'b0, cfg_r.rate}) begin
                    rampPos_r <= target_r;
                end else if (sgnDiff(rampPos_r, target_r)) begin
                    rampPos_r <= rampPos_r + cfg_r.rate;
                end else begin
                    rampPos_r <= rampPos_r - cfg_r.rate;
                end
            end
        end
    end
    // serial divider for scaling gain
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            divPending_r <= 1'b1;
            divBusy_r <= 1'b0;
            divCnt_r <= 6'h00;
            divNum_r <= '0;
            divDen_r <= '0;
            divRem_r <= '0;
            divNeg_r <= 1'b0;
            gain_r <= '0;
            gainValid_r <= 1'b0;
        end else if (scaleWrite) begin
            divPending_r <= 1'b1;
            divBusy_r <= 1'b0;
            gainValid_r <= 1'b0;
        end else if (divPending_r) begin
            divPending_r <= 1'b0;
            divBusy_r <= 1'b1;
            divCnt_r <= 6'h00;
            divNum_r <= {absDiff(cfg_r.highSignal, cfg_r.lowSignal), 16'h0000};
            divDen_r <= absDiff(cfg_r.upperScale, cfg_r.lowerScale);
            divRem_r <= '0;
            divNeg_r <= sgnDiff(cfg_r.highSignal, cfg_r.lowSignal) ^
                        sgnDiff(cfg_r.upperScale, cfg_r.lowerScale);
        end else if (divBusy_r) begin
            if (divCnt_r == DIV_STEPS) begin
                divBusy_r <= 1'b0;
                gainValid_r <= 1'b1;
                gain_r <= divNeg_r ? -$signed({1'b0, divNum_r}) : $signed({1'b0, divNum_r});
            end else begin
                divCnt_r <= divCnt_r + 6'h01;
                if ({divRem_r[32:0], divNum_r[48]} >= {1'b0, divDen_r}) begin
                    divRem_r <= {divRem_r[32:0], divNum_r[48]} - {1'b0, divDen_r};
                    divNum_r <= {divNum_r[47:0], 1'b1};
                end else begin
                    divRem_r <= {divRem_r[32:0], divNum_r[48]};
                    divNum_r <= {divNum_r[47:0], 1'b0};
                end
            end
        end
    end
    // scaling to output current
    logic signed [32:0] scaleOfs;
    logic signed [82:0] scaleProd;
    assign scaleOfs = $signed({rampPos_r[31], rampPos_r}) -
                      $signed({cfg_r.lowerScale[31], cfg_r.lowerScale});
    assign scaleProd = scaleOfs * gain_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scaled_r <= RST_LOW_SIGNAL;
        end else begin
            // RULE13 low and high signal mapping
            scaled_r <= cfg_r.lowSignal + scaleProd[GAIN_FRAC+31:GAIN_FRAC];
        end
    end
    // fault state machine
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= ST_NORMAL;
        end else begin
            case (state_r)
                ST_NORMAL: begin
                    // RULE14 enter fault handling
                    if (faultNow) begin
                        state_r <= ST_SUBST;
                    end
                end
                ST_SUBST: begin
                    if (!faultNow) begin
                        state_r <= ST_NORMAL;
                    // RULE6 duration elapsed
                    // RULE7 zero duration never expires
                    end else if (cfg_r.duration != 16'h0000 && secCnt_r >= cfg_r.duration) begin
                        state_r <= ST_FINAL;
                    end
                end
                ST_FINAL: begin
                    if (!faultNow) begin
                        state_r <= ST_NORMAL;
                    end
                end
                default: state_r <= ST_NORMAL;
            endcase
        end
    end
    // fault duration timer, restarted on every entry
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msCnt_r <= 10'h000;
            secCnt_r <= 16'h0000;
        end else if (state_r == ST_NORMAL) begin
            // RULE14 restart timer
            msCnt_r <= 10'h000;
            secCnt_r <= 16'h0000;
        end else if (msTick) begin
            if (msCnt_r == MS_PER_S - 10'h001) begin
                msCnt_r <= 10'h000;
                if (secCnt_r != 16'hffff) begin
                    secCnt_r <= secCnt_r + 16'h0001;
                end
            end else begin
                msCnt_r <= msCnt_r + 10'h001;
            end
        end
    end
    // output selection and clamp
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aoOut_r <= RST_LOWER_LIMIT;
            holdVal_r <= RST_LOWER_LIMIT;
        end else begin
            case (state_r)
                ST_NORMAL: begin
                    holdVal_r <= aoOut_r;
                    // RULE1 lower limit clamp
                    if ($signed(scaled_r) < $signed(cfg_r.lowerLimit)) begin
                        aoOut_r <= cfg_r.lowerLimit;
                    // RULE2 upper limit clamp
                    end else if ($signed(scaled_r) > $signed(cfg_r.upperLimit)) begin
                        aoOut_r <= cfg_r.upperLimit;
                    end else begin
                        aoOut_r <= scaled_r;
                    end
                end
                // RULE4 hold or substitute
                // RULE5 substitute value
                ST_SUBST: aoOut_r <= cfg_r.faultUser ? cfg_r.substValue : holdVal_r;
                // RULE9 final value
                ST_FINAL: aoOut_r <= cfg_r.finalValue;
                default: aoOut_r <= cfg_r.finalValue;
            endcase
        end
    end

    // hart gating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hartStart_r <= 1'b0;
        end else begin
            // RULE12 hart switch
            hartStart_r <= hartReq && cfg_r.hartOn;
        end
    end
    logic faultActive_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            faultActive_r <= 1'b0;
        end else begin
            faultActive_r <= faultNow;
        end
    end
    assign regRdata = regRdata_r;
    assign hartStart = hartStart_r;
    assign aoOut = aoOut_r;
    assign faultActive = faultActive_r;
    assign cfgError = cfgError_r;
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    low_clamp_a: assert property (state_r == ST_NORMAL && $past(state_r) == ST_NORMAL && !$past(regWrite) && !regWrite |-> ##1 $signed(aoOut_r) >= $signed(cfg_r.lowerLimit) || $signed(cfg_r.lowerLimit) > $signed(cfg_r.upperLimit)) else $error("output below lower limit"); // RULE1
    high_clamp_a: assert property (state_r == ST_NORMAL && !regWrite && $signed(cfg_r.lowerLimit) <= $signed(cfg_r.upperLimit) |=> $signed(aoOut_r) <= $signed($past(cfg_r.upperLimit))) else $error("output above upper limit"); // RULE2
    range_error_a: assert property ($signed(cfg_r.lowSignal) >= $signed(cfg_r.highSignal) && !regWrite |=> ##1 cfgError_r.rangeOrder) else $error("range order error missed"); // RULE3
    hold_last_a: assert property (state_r == ST_SUBST && !cfg_r.faultUser |=> aoOut_r == holdVal_r) else $error("hold value not driven"); // RULE4
    subst_value_a: assert property (state_r == ST_SUBST && cfg_r.faultUser |=> aoOut_r == $past(cfg_r.substValue)) else $error("substitute not driven"); // RULE5
    final_entry_a: assert property (state_r == ST_SUBST && faultNow && cfg_r.duration != 16'h0000 && secCnt_r >= cfg_r.duration |=> state_r == ST_FINAL) else $error("final state not entered"); // RULE6
    zero_hold_a: assert property (state_r == ST_SUBST && cfg_r.duration == 16'h0000 |=> state_r != ST_FINAL) else $error("left hold with zero duration"); // RULE7
    dur_error_a: assert property (cfg_r.duration > DURATION_MAX_S && !regWrite |=> ##1 cfgError_r.durationLong) else $error("duration error missed"); // RULE8
    final_value_a: assert property (state_r == ST_FINAL |=> aoOut_r == $past(cfg_r.finalValue)) else $error("final value not driven"); // RULE9
    ramp_off_a: assert property (!cfg_r.rampOn |=> rampPos_r == $past(target_r)) else $error("value not passed through"); // RULE10
    ramp_rate_a: assert property (cfg_r.rampOn |=> absDiff(rampPos_r, $past(rampPos_r)) <= {1'b0, $past(cfg_r.rate)} && (msTick || $stable(rampPos_r) || $past(msTick))) else $error("ramp rate exceeded"); // RULE11
    hart_block_a: assert property (!cfg_r.hartOn |=> !hartStart_r) else $error("hart attempt while off"); // RULE12
    scale_zero_a: assert property (gainValid_r && rampPos_r == cfg_r.lowerScale |=> scaled_r == $past(cfg_r.lowSignal)) else $error("low signal mapping wrong"); // RULE13
    fault_entry_a: assert property (state_r == ST_NORMAL && faultNow |=> state_r == ST_SUBST ##1 secCnt_r == 16'h0000 || !faultNow) else $error("fault entry wrong"); // RULE14

    final_seen_c: cover property (state_r == ST_SUBST ##1 state_r == ST_FINAL);
    ramp_move_c: cover property (cfg_r.rampOn && msTick ##1 $changed(rampPos_r));
    recover_c: cover property (state_r == ST_SUBST ##1 state_r == ST_NORMAL);
    error_seen_c: cover property ($rose(cfgError_r.durationLong));
endmodule : analog_output_channel_control
`default_nettype wire

// file: inc/ao_channel_pkg.sv
// Purpose: constants, register map and carrier types for the analog output channel
// Assumes: values are signed 32-bit fixed point in micro units (1e-6 mA or scale unit)
// Notes: rate is in milli units per second, i.e. micro units per millisecond
package ao_channel_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOWER_LIMIT = 8'h04;
    localparam logic [7:0] OFS_UPPER_LIMIT = 8'h08;
    localparam logic [7:0] OFS_SUBST_VALUE = 8'h0c;
    localparam logic [7:0] OFS_DURATION = 8'h10;
    localparam logic [7:0] OFS_FINAL_VALUE = 8'h14;
    localparam logic [7:0] OFS_RATE = 8'h18;
    localparam logic [7:0] OFS_LOW_SIGNAL = 8'h1c;
    localparam logic [7:0] OFS_HIGH_SIGNAL = 8'h20;
    localparam logic [7:0] OFS_LOWER_SCALE = 8'h24;
    localparam logic [7:0] OFS_UPPER_SCALE = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_OUTPUT = 8'h30;
    // control field positions
    localparam int CTRL_USER_BIT = 0;
    localparam int CTRL_RAMP_BIT = 1;
    localparam int CTRL_HART_BIT = 2;
    // reset values
    localparam logic RST_FAULT_USER = 1'b1;
    localparam logic RST_RAMP_ON = 1'b0;
    localparam logic RST_HART_ON = 1'b1;
    localparam logic [31:0] RST_LOWER_LIMIT = 32'h0000_0000;
    localparam logic [31:0] RST_UPPER_LIMIT = 32'h014f_b180;
    localparam logic [31:0] RST_SUBST_VALUE = 32'h0000_0000;
    localparam logic [15:0] RST_DURATION = 16'h0000;
    localparam logic [31:0] RST_FINAL_VALUE = 32'h0000_0000;
    localparam logic [31:0] RST_RATE = 32'h0000_03e8;
    localparam logic [31:0] RST_LOW_SIGNAL = 32'h003d_0900;
    localparam logic [31:0] RST_HIGH_SIGNAL = 32'h0131_2d00;
    localparam logic [31:0] RST_LOWER_SCALE = 32'h003d_0900;
    localparam logic [31:0] RST_UPPER_SCALE = 32'h0131_2d00;
    localparam logic [15:0] DURATION_MAX_S = 16'h1c20;
    localparam logic [31:0] RATE_MIN = 32'h0000_0001;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_TICK_NS = 1_000_000;
    localparam int CYCLES_PER_MS = (MS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] MS_PER_S = 10'h3e8;
    localparam int GAIN_FRAC = 16;
    localparam logic [5:0] DIV_STEPS = 6'h31;
    // fault state, gray along normal -> substitute -> final
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_SUBST = 2'b01,
        ST_FINAL = 2'b11
    } fault_state_t;
    typedef struct packed {
        logic faultUser;
        logic rampOn;
        logic hartOn;
        logic [31:0] lowerLimit;
        logic [31:0] upperLimit;
        logic [31:0] substValue;
        logic [15:0] duration;
        logic [31:0] finalValue;
        logic [31:0] rate;
        logic [31:0] lowSignal;
        logic [31:0] highSignal;
        logic [31:0] lowerScale;
        logic [31:0] upperScale;
    } cfg_t;
    typedef struct packed {
        logic rangeOrder;
        logic durationLong;
    } cfg_err_t;
endpackage : ao_channel_pkg

// file: testbench/bus_ctrl_model.sv
// Purpose: fieldbus controller model sending cyclic output values
// Assumes: one value per send, valid high for one cycle
// Notes: value line shows the inverse of the last value while idle
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
    // clock
    input wire logic clock,
    // cyclic value
    output var logic [31:0] busValue,
    output var logic busValid
);
    initial begin
        busValue = 32'h0;
        busValid = 1'b0;
    end
    task automatic send(input logic [31:0] v);
        @(posedge clock);
        busValue <= v;
        busValid <= 1'b1;
        @(posedge clock);
        busValid <= 1'b0;
        busValue <= ~v;
    endtask : send
endmodule : bus_ctrl_model
`default_nettype wire

// file: testbench/tb.sv
// Purpose: self-checking bench for the analog output channel
// Assumes: one ms tick every 10 cycles, so one second is 10000 cycles
// Notes: register rows and bus values run from one table
`timescale 1ns/1ps
`default_nettype none
module tb
    import ao_channel_pkg::*;
();
    typedef struct packed {
        logic isBus;
        logic [7:0] addr;
        logic [31:0] val;
        logic [31:0] expv;
    } row_t;
    logic clock = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, busValid;
    logic chanFault = 1'b0, commFault = 1'b0, hartReq = 1'b0, hartStart, faultActive;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, busValue, aoOut, rdv, diff;
    cfg_err_t cfgError;
    row_t rows [13];
    int nErrors = 0, checks = 0, cycles = 0;
    analog_output_channel_control #(.CyclesPerMs(10)) uut (.clock(clock), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .busValue(busValue), .busValid(busValid),
        .chanFault(chanFault), .commFault(commFault), .hartReq(hartReq),
        .hartStart(hartStart), .aoOut(aoOut), .faultActive(faultActive),
        .cfgError(cfgError));
    bus_ctrl_model ctrl (.clock(clock), .busValue(busValue), .busValid(busValid));
    initial begin
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            nErrors++;
            test_done();
        end
    end
    task automatic test_done();
        if (nErrors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        rdv = regRdata;
    endtask : rd
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            nErrors++;
            $display("Error %s expected %h got %h", nm, e, g);
        end
    endtask : chk32
    task automatic chk1(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            nErrors++;
            $display("Error %s expected %b got %b", nm, e, g);
        end
    endtask : chk1
    task automatic hart(input logic e);
        @(posedge clock);
        hartReq <= 1'b1;
        @(posedge clock);
        hartReq <= 1'b0;
        #1;
        chk1("hartStart", e, hartStart);
    endtask : hart
    initial begin
        rows = '{{1'b0, OFS_CTRL, 32'h0, 32'h0000_0005}, {1'b0, OFS_LOWER_LIMIT, 32'h0,
            RST_LOWER_LIMIT}, {1'b0, OFS_UPPER_LIMIT, 32'h0, RST_UPPER_LIMIT},
            {1'b0, OFS_SUBST_VALUE, 32'h0, RST_SUBST_VALUE}, {1'b0, OFS_DURATION, 32'h0,
            32'h0}, {1'b0, OFS_FINAL_VALUE, 32'h0, RST_FINAL_VALUE}, {1'b0, OFS_RATE,
            32'h0, RST_RATE}, {1'b0, OFS_LOW_SIGNAL, 32'h0, RST_LOW_SIGNAL},
            {1'b0, 8'h34, 32'h0, 32'h0}, {1'b1, 8'h00, 32'h00b7_1b00, 32'h00b7_1b00},
            {1'b1, 8'h00, 32'h01c9_c380, RST_UPPER_LIMIT},
            {1'b1, 8'h00, 32'hfff0_bdc0, 32'h0}, {1'b1, 8'h00, 32'h00b7_1b00, 32'h00b7_1b00}};
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        cyc(60);
        foreach (rows[i]) begin
            if (rows[i].isBus) begin
                ctrl.send(rows[i].val);
                cyc(5);
                rdv = aoOut;
            end else rd(rows[i].addr);
            chk32("rowResult", rows[i].expv, rdv);
        end
        wr(OFS_LOW_SIGNAL, RST_HIGH_SIGNAL);
        cyc(3);
        chk1("rangeOrder", 1'b1, cfgError.rangeOrder);
        wr(OFS_LOW_SIGNAL, RST_LOW_SIGNAL);
        cyc(3);
        chk1("rangeOrder", 1'b0, cfgError.rangeOrder);
        wr(OFS_DURATION, 32'h0000_1c21);
        cyc(3);
        chk1("durationLong", 1'b1, cfgError.durationLong);
        wr(OFS_DURATION, 32'h0000_1c20);
        cyc(3);
        chk1("durationLong", 1'b0, cfgError.durationLong);
        hart(1'b1);
        wr(OFS_CTRL, 32'h0000_0001);
        hart(1'b0);
        wr(OFS_SUBST_VALUE, 32'h006a_cfc0);
        wr(OFS_FINAL_VALUE, 32'h0089_5440);
        wr(OFS_DURATION, 32'h0000_0001);
        cyc(60);
        @(posedge clock) chanFault <= 1'b1;
        cyc(4);
        chk32("aoOutSubst", 32'h006a_cfc0, aoOut);
        chk1("faultActive", 1'b1, faultActive);
        cyc(6000);
        @(posedge clock) chanFault <= 1'b0;
        cyc(6);
        chk32("aoOutNormal", 32'h00b7_1b00, aoOut);
        chk1("faultActive", 1'b0, faultActive);
        @(posedge clock) commFault <= 1'b1;
        cyc(6000);
        chk32("aoOutRestart", 32'h006a_cfc0, aoOut);
        cyc(4100);
        chk32("aoOutFinal", 32'h0089_5440, aoOut);
        @(posedge clock) commFault <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0004);
        wr(OFS_DURATION, 32'h0);
        cyc(6);
        @(posedge clock) commFault <= 1'b1;
        cyc(4);
        chk32("aoOutHold", 32'h00b7_1b00, aoOut);
        cyc(10100);
        chk32("aoOutHold", 32'h00b7_1b00, aoOut);
        @(posedge clock) commFault <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0006);
        cyc(6);
        ctrl.send(32'h00c6_5d40);
        cyc(55);
        diff = aoOut - 32'h00b7_1b00;
        chk1("rampStep", 1'b1, diff > 32'h0 && diff <= 32'h0000_1b58);
        wr(OFS_CTRL, 32'h0000_0004);
        cyc(6);
        chk32("aoOutDirect", 32'h00c6_5d40, aoOut);
        // scale 0..8 maps onto 4..20 mA, so value 2 gives 8 mA
        wr(OFS_LOWER_SCALE, 32'h0);
        wr(OFS_UPPER_SCALE, 32'h007a_1200);
        ctrl.send(32'h001e_8480);
        cyc(60);
        chk32("aoOutScaled", 32'h007a_1200, aoOut);
        // reset in mid-run
        @(posedge clock) rst <= 1'b1;
        cyc(2);
        chk32("aoOutReset", RST_LOWER_LIMIT, aoOut);
        chk1("faultActiveReset", 1'b0, faultActive);
        chk1("hartStartReset", 1'b0, hartStart);
        chk1("cfgErrorReset", 1'b0, |cfgError);
        @(posedge clock) rst <= 1'b0;
        cyc(3);
        chk32("aoOutRelease", RST_LOW_SIGNAL, aoOut);
        rd(OFS_CTRL);
        chk32("ctrlReset", {29'h0, RST_HART_ON, RST_RAMP_ON, RST_FAULT_USER}, rdv);
        test_done();
    end
endmodule : tb
`default_nettype wire
